/* File: shared/ppcs_cfg.svh */
// Offsets, bit positions and reset values of the port PHY control/status bank
`ifndef PPCS_CFG_SVH
`define PPCS_CFG_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define PPCS_IDX_P1_CTRL   6'h1D
`define PPCS_IDX_P1_STAT   6'h1E
`define PPCS_IDX_P1_STATX  6'h1F
`define PPCS_IDX_P2_CTRL   6'h2D
`define PPCS_IDX_P2_STAT   6'h2E
`define PPCS_IDX_P2_STATX  6'h2F
`define PPCS_IDX_P3_RSVC   6'h3D
`define PPCS_IDX_P3_RSVS   6'h3E
`define PPCS_IDX_P3_STATX  6'h3F

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define PPCS_CTL_LED_OFF   7
`define PPCS_CTL_TX_DIS    6
`define PPCS_CTL_RESTART   5
`define PPCS_CTL_FEF_DIS   4
`define PPCS_CTL_PWR_DN    3
`define PPCS_CTL_XO_DIS    2
`define PPCS_CTL_FORCE_MDI 1
`define PPCS_CTL_LOOP      0

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define PPCS_ST_MDIX       7
`define PPCS_ST_NEGOTIATION_COMPLETE    6
`define PPCS_ST_LINK       5
`define PPCS_SX_XALG       7
`define PPCS_SX_RSVD       6
`define PPCS_SX_POL        5

// ----------------------------------------
// Reset values and the LED-off blank pattern
// ----------------------------------------
`define PPCS_CTL_RST       8'h00
`define PPCS_XALG_RST      1'b1
`define PPCS_LED_BLANK     4'hF

`endif

/* File: shared/ppcs_pkg.sv */
// Types shared by the port PHY control/status bank
package ppcs_pkg;

  // APB slave phase, one-hot
  typedef enum logic [1:0] {
    PPCS_IDLE   = 2'b01,
    PPCS_ACCESS = 2'b10
  } ppcs_apb_st_t;

  typedef logic [7:0] ppcs_byte_t;

endpackage : ppcs_pkg

/* File: rtl/ppcs_regs.sv */
// Port PHY control and status register bank with APB slave
`timescale 1ns/1ps
`include "ppcs_cfg.svh"

// Function
// [RL1] LED-off bit drives all four port LED pins high; clear restores them.
// [RL2] Transmit-disable bit turns the port transmitter off.
// [RL3] Writing one to restart bit restarts auto-negotiation on that port.
// [RL4] Port 1 fault-disable bit stops far-end fault detect and pattern send.
// [RL5] Crossover-disable bit stops auto crossover; port 2 resets from strap.
// [RL6] Force bit picks MDI or MDI-X when auto off; port 2 resets from strap.
// [RL7] Loopback bit loops the other port's traffic at this port's PHY.
// [RL8] Status shows crossover state, negotiation done, link good; reset zero.
// [RL9] Status bits 4..0 show partner pause, 100F, 100H, 10F, 10H.
// [RL10] Second status bit 7 selects crossover algorithm, default one, not port 3.
// [RL11] Second status bit 5 shows receive polarity reversed, not port 3.
// [RL12] Second status bit 4 shows transmit flow control active.
// [RL13] Second status bit 3 shows receive flow control active.
// [RL14] Second status bit 2 shows speed, one for 100 Mbps.
// [RL15] Second status bit 1 shows duplex, one for full.
// [RL16] Second status bit 0 shows far-end fault, port 1 only.
// [RL17] Second status bit 6 is reserved and reads zero.
// [RL18] Port register sets sit at 0x1D, 0x2D; port 3 second status at 0x3F.
// [RL19] Port 3 control and status slots are reserved with no controls.
// [RL20] Power-down bit places the port PHY in power down.
module ppcs_regs (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_sys_rst,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Strap pins
  input  wire logic        i_port2_crossover_disable_strap,
  input  wire logic        i_port2_force_pairing_strap,
  // PHY status, index 0 is port 1
  input  wire logic [1:0]  i_mdix_status,
  input  wire logic [1:0]  i_negotiation_complete,
  input  wire logic [1:0]  i_link_good,
  input  wire logic [9:0]  i_partner_ability,
  input  wire logic [1:0]  i_polarity_reversed,
  input  wire logic        i_far_end_fault,
  // MAC status, index 2 is port 3
  input  wire logic [2:0]  i_tx_flow_active,
  input  wire logic [2:0]  i_rx_flow_active,
  input  wire logic [2:0]  i_speed_100,
  input  wire logic [2:0]  i_full_duplex,
  // LED sources from the port LED logic
  input  wire logic [7:0]  i_port_led_src,
  // PHY controls
  output logic      [7:0]  o_port_led,
  output logic      [1:0]  o_tx_disable,
  output logic      [1:0]  o_negotiation_restart,
  output logic             o_far_end_fault_disable,
  output logic      [1:0]  o_power_down,
  output logic      [1:0]  o_crossover_disable,
  output logic      [1:0]  o_force_mdi,
  output logic      [1:0]  o_loopback,
  output logic      [1:0]  o_crossover_algorithm_select
);

  // ----------------------------------------
  // Strap synchronisers
  // ----------------------------------------
  // Not reset, so the pin level flows through while reset is held
  logic [1:0] strap_s1_reg;
  logic [1:0] strap_s2_reg;

  always_ff @(posedge i_clk_sys) begin
    strap_s1_reg <= {i_port2_crossover_disable_strap, i_port2_force_pairing_strap};
    strap_s2_reg <= strap_s1_reg;
  end

  // ----------------------------------------
  // APB phase tracking
  // ----------------------------------------
  ppcs_pkg::ppcs_apb_st_t apb_st_reg;
  ppcs_pkg::ppcs_apb_st_t apb_st_next;

  wire        setup_ph = i_psel & ~i_penable;
  wire        access_ph = i_psel & i_penable;
  wire [5:0]  idx = i_paddr[7:2];
  wire        in_access = (apb_st_reg == ppcs_pkg::PPCS_ACCESS);
  wire        wr_en = access_ph & in_access & i_pwrite & i_pstrb[0];

  always_comb begin
    case (apb_st_reg)
      ppcs_pkg::PPCS_IDLE: begin
        apb_st_next = setup_ph ? ppcs_pkg::PPCS_ACCESS : ppcs_pkg::PPCS_IDLE;
      end
      ppcs_pkg::PPCS_ACCESS: begin
        apb_st_next = setup_ph ? ppcs_pkg::PPCS_ACCESS : ppcs_pkg::PPCS_IDLE;
      end
      default: begin
        apb_st_next = ppcs_pkg::PPCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      apb_st_reg <= ppcs_pkg::PPCS_IDLE;
    end else begin
      apb_st_reg <= apb_st_next;
    end
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire hit_p1_ctl  = (idx == `PPCS_IDX_P1_CTRL);                          // RL18
  wire hit_p1_st   = (idx == `PPCS_IDX_P1_STAT);                          // RL18
  wire hit_p1_sx   = (idx == `PPCS_IDX_P1_STATX);                         // RL18
  wire hit_p2_ctl  = (idx == `PPCS_IDX_P2_CTRL);                          // RL18
  wire hit_p2_st   = (idx == `PPCS_IDX_P2_STAT);                          // RL18
  wire hit_p2_sx   = (idx == `PPCS_IDX_P2_STATX);                         // RL18
  wire hit_p3_rsv  = (idx == `PPCS_IDX_P3_RSVC) |
                     (idx == `PPCS_IDX_P3_RSVS);                          // RL19
  wire hit_p3_sx   = (idx == `PPCS_IDX_P3_STATX);                         // RL18
  wire mapped      = hit_p1_ctl | hit_p1_st | hit_p1_sx | hit_p2_ctl |
                     hit_p2_st | hit_p2_sx | hit_p3_rsv | hit_p3_sx;

  wire [1:0] hit_ctl = {hit_p2_ctl, hit_p1_ctl};
  wire [1:0] hit_sx  = {hit_p2_sx, hit_p1_sx};

  // ----------------------------------------
  // Per PHY port control and status
  // ----------------------------------------
  ppcs_pkg::ppcs_byte_t ctrl_reg [2];
  ppcs_pkg::ppcs_byte_t stat0 [2];
  ppcs_pkg::ppcs_byte_t statx [3];
  logic [1:0]           xalg_reg;
  logic [1:0]           restart_reg;
  logic [7:0]           led_reg;

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_port
      wire       wr_ctl = wr_en & hit_ctl[p];
      wire       wr_sx  = wr_en & hit_sx[p];
      wire [7:0] ctl_next;
      // Restart is a command: it never stays set in the register
      assign ctl_next = wr_ctl ? (i_pwdata[7:0] & ~8'h20) : ctrl_reg[p];  // RL3

      always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
          ctrl_reg[p] <= `PPCS_CTL_RST;
          if (p == 1) begin
            ctrl_reg[p][`PPCS_CTL_XO_DIS]    <= strap_s2_reg[1];          // RL5
            ctrl_reg[p][`PPCS_CTL_FORCE_MDI] <= strap_s2_reg[0];          // RL6
          end
          xalg_reg[p]    <= `PPCS_XALG_RST;
          restart_reg[p] <= 1'b0;
          led_reg[p*4 +: 4] <= 4'h0;
        end else begin
          ctrl_reg[p]    <= ctl_next;
          restart_reg[p] <= wr_ctl & i_pwdata[`PPCS_CTL_RESTART];         // RL3
          if (wr_sx) begin
            xalg_reg[p] <= i_pwdata[`PPCS_SX_XALG];                       // RL10
          end
          led_reg[p*4 +: 4] <= ctl_next[`PPCS_CTL_LED_OFF] ?
                               `PPCS_LED_BLANK : i_port_led_src[p*4 +: 4]; // RL1
        end
      end

      assign stat0[p] = {i_mdix_status[p],
                         i_negotiation_complete[p],
                         i_link_good[p],
                         i_partner_ability[p*5 +: 5]};                    // RL8 RL9
      assign statx[p] = {xalg_reg[p],                                     // RL10
                         1'b0,                                            // RL17
                         i_polarity_reversed[p],                          // RL11
                         i_tx_flow_active[p],                             // RL12
                         i_rx_flow_active[p],                             // RL13
                         i_speed_100[p],                                  // RL14
                         i_full_duplex[p],                                // RL15
                         (p == 0) ? i_far_end_fault : 1'b0};              // RL16
    end
  endgenerate

  // Port 3 is MII only: no algorithm or polarity bits
  assign statx[2] = {2'b00, 1'b0,
                     i_tx_flow_active[2],
                     i_rx_flow_active[2],
                     i_speed_100[2],
                     i_full_duplex[2],
                     1'b0};                                               // RL10 RL11 RL16

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire [7:0] rd_byte = hit_p1_ctl ? ctrl_reg[0] :
                       hit_p1_st  ? stat0[0]    :
                       hit_p1_sx  ? statx[0]    :
                       hit_p2_ctl ? ctrl_reg[1] :
                       hit_p2_st  ? stat0[1]    :
                       hit_p2_sx  ? statx[1]    :
                       hit_p3_sx  ? statx[2]    : 8'h00;                  // RL19

  // Read data is captured in setup so it stands stable through access
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_prdata  <= 32'h0000_0000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      if (setup_ph) begin
        o_prdata <= {24'h00_0000, rd_byte};
      end
      o_pready  <= setup_ph;
      o_pslverr <= setup_ph & ~mapped;
    end
  end

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_tx_disable                 <= 2'b00;
      o_far_end_fault_disable      <= 1'b0;
      o_power_down                 <= 2'b00;
      o_crossover_disable          <= 2'b00;
      o_force_mdi                  <= 2'b00;
      o_loopback                   <= 2'b00;
      o_crossover_algorithm_select <= {2{`PPCS_XALG_RST}};
    end else begin
      o_tx_disable  <= {ctrl_reg[1][`PPCS_CTL_TX_DIS], ctrl_reg[0][`PPCS_CTL_TX_DIS]};    // RL2
      o_far_end_fault_disable <= ctrl_reg[0][`PPCS_CTL_FEF_DIS];                       // RL4
      o_power_down  <= {ctrl_reg[1][`PPCS_CTL_PWR_DN], ctrl_reg[0][`PPCS_CTL_PWR_DN]};    // RL20
      o_crossover_disable <= {ctrl_reg[1][`PPCS_CTL_XO_DIS],
                              ctrl_reg[0][`PPCS_CTL_XO_DIS]};                          // RL5
      o_force_mdi   <= {ctrl_reg[1][`PPCS_CTL_FORCE_MDI],
                        ctrl_reg[0][`PPCS_CTL_FORCE_MDI]};                             // RL6
      o_loopback    <= {ctrl_reg[1][`PPCS_CTL_LOOP], ctrl_reg[0][`PPCS_CTL_LOOP]};      // RL7
      o_crossover_algorithm_select <= xalg_reg;                                        // RL10
    end
  end

  assign o_port_led            = led_reg;
  assign o_negotiation_restart = restart_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  led_blank_a: assert property ( // RL1
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (wr_en && hit_p1_ctl && i_pwdata[`PPCS_CTL_LED_OFF]) |=> o_port_led[3:0] == 4'hF)
    else $error("port 1 LEDs not blanked after LED-off write");

  tx_disable_a: assert property ( // RL2
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (wr_en && hit_p2_ctl) |=> ##1 o_tx_disable[1] == $past(i_pwdata[`PPCS_CTL_TX_DIS], 2))
    else $error("port 2 transmit disable does not follow write");

  restart_pulse_a: assert property ( // RL3
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (wr_en && hit_p1_ctl && i_pwdata[`PPCS_CTL_RESTART])
      |=> o_negotiation_restart[0] ##1 !o_negotiation_restart[0])
    else $error("restart is not a single-cycle pulse");

  fault_disable_a: assert property ( // RL4
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (wr_en && hit_p1_ctl) |=> ##1 o_far_end_fault_disable == $past(i_pwdata[4], 2))
    else $error("fault disable does not follow port 1 write");

  strap_load_a: assert property ( // RL5
    @(posedge i_clk_sys)
    $fell(i_sys_rst) |-> ctrl_reg[1][`PPCS_CTL_XO_DIS] == $past(strap_s2_reg[1]))
    else $error("port 2 crossover disable not loaded from strap");

  loopback_set_a: assert property ( // RL7
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (wr_en && hit_p1_ctl) |=> ##1 o_loopback[0] == $past(i_pwdata[0], 2))
    else $error("port 1 loopback does not follow write");

  status_read_a: assert property ( // RL8
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (setup_ph && hit_p2_st) |=> o_pready && o_prdata[7:0] == $past(stat0[1]))
    else $error("port 2 status read mismatch");

  rsvd_zero_a: assert property ( // RL17
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (setup_ph && (hit_p1_sx || hit_p2_sx || hit_p3_sx)) |=> !o_prdata[`PPCS_SX_RSVD])
    else $error("reserved status bit reads one");

  port3_slot_a: assert property ( // RL19
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (setup_ph && hit_p3_rsv) |=> o_prdata == 32'h0000_0000 && !o_pslverr)
    else $error("port 3 reserved slot not zero");

  port3_xalg_a: assert property ( // RL10
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (setup_ph && hit_p3_sx) |=> o_prdata[7] == 1'b0 && o_prdata[5] == 1'b0)
    else $error("port 3 reads PHY-only bits");

  port2_restart_a: assert property ( // RL3
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (wr_en && hit_p2_ctl && i_pwdata[`PPCS_CTL_RESTART])
      |=> o_negotiation_restart[1] ##1 !o_negotiation_restart[1])
    else $error("port 2 restart is not a single-cycle pulse");

  power_down_a: assert property ( // RL20
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (wr_en && hit_p1_ctl) |=> ##1 o_power_down[0] == $past(i_pwdata[`PPCS_CTL_PWR_DN], 2))
    else $error("port 1 power down does not follow write");

  force_mdi_a: assert property ( // RL6
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (wr_en && hit_p2_ctl) |=> ##1 o_force_mdi[1] == $past(i_pwdata[`PPCS_CTL_FORCE_MDI], 2))
    else $error("port 2 force pairing does not follow write");

  xo_disable_a: assert property ( // RL5
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (wr_en && hit_p1_ctl) |=> ##1 o_crossover_disable[0] == $past(i_pwdata[`PPCS_CTL_XO_DIS], 2))
    else $error("port 1 crossover disable does not follow write");

  led_follow_a: assert property ( // RL1
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (!wr_en && !ctrl_reg[1][`PPCS_CTL_LED_OFF]) |=> o_port_led[7:4] == $past(i_port_led_src[7:4]))
    else $error("port 2 LEDs do not follow their source");

  xalg_write_a: assert property ( // RL10
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (wr_en && hit_p1_sx) |=> ##1 o_crossover_algorithm_select[0] == $past(i_pwdata[7], 2))
    else $error("port 1 algorithm select does not follow write");

  unmapped_err_a: assert property ( // RL18
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (setup_ph && !mapped) |=> o_pready && o_pslverr && o_prdata == 32'h0000_0000)
    else $error("unmapped access not answered with error");

  far_fault_a: assert property ( // RL16
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (setup_ph && hit_sx != 2'b00)
      |=> o_prdata[0] == ($past(hit_p1_sx) && $past(i_far_end_fault)))
    else $error("far-end fault bit wrong for port");

  polarity_read_a: assert property ( // RL11
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (setup_ph && hit_p1_sx) |=> o_prdata[5] == $past(i_polarity_reversed[0]))
    else $error("port 1 polarity bit mismatch");

  tx_flow_a: assert property ( // RL12
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (setup_ph && hit_p3_sx) |=> o_prdata[4] == $past(i_tx_flow_active[2]))
    else $error("port 3 transmit flow bit mismatch");

  rx_flow_a: assert property ( // RL13
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (setup_ph && hit_p2_sx) |=> o_prdata[3] == $past(i_rx_flow_active[1]))
    else $error("port 2 receive flow bit mismatch");

  speed_read_a: assert property ( // RL14
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (setup_ph && hit_p1_sx) |=> o_prdata[2] == $past(i_speed_100[0]))
    else $error("port 1 speed bit mismatch");

  duplex_read_a: assert property ( // RL15
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (setup_ph && hit_p3_sx) |=> o_prdata[1] == $past(i_full_duplex[2]))
    else $error("port 3 duplex bit mismatch");

  rsvd_write_a: assert property ( // RL19
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (wr_en && hit_p3_rsv)
      |=> ctrl_reg[0] == $past(ctrl_reg[0]) && ctrl_reg[1] == $past(ctrl_reg[1]))
    else $error("reserved slot write changed a control register");

endmodule : ppcs_regs

/* File: test/port_phy_control_status_test.sv */
// Self-checking bench for the port PHY control/status register bank
`timescale 1ns/1ps
`include "ppcs_cfg.svh"
`define CHK(what, exp, got) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("unexpected %s: expected %0h seen %0h", what, exp, got); \
  end \
end
module port_phy_control_status_test;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk_sys, sys_rst, psel, penable, pwrite;
  logic [7:0]  paddr, led_src, v, exp_led;
  logic [31:0] pwdata, prdata, rdv, pat;
  logic [3:0]  pstrb;
  logic        xo_strap, force_strap, fef;
  logic [1:0]  mdix, an, link, pol, tx_dis, restart, pwr_dn, xo_dis, frc, loop, alg;
  logic [9:0]  ability;
  logic [2:0]  txf, rxf, spd, dup;
  logic        pready, pslverr, fef_dis;
  logic [7:0]  led;
  int          bad_count, check_count;
  int          pulse_cnt [2];
  // ----------------------------------------
  // Design
  // ----------------------------------------
  ppcs_regs dut (.i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_port2_crossover_disable_strap(xo_strap), .i_port2_force_pairing_strap(force_strap),
    .i_mdix_status(mdix), .i_negotiation_complete(an), .i_link_good(link),
    .i_partner_ability(ability), .i_polarity_reversed(pol), .i_far_end_fault(fef),
    .i_tx_flow_active(txf), .i_rx_flow_active(rxf), .i_speed_100(spd),
    .i_full_duplex(dup), .i_port_led_src(led_src), .o_port_led(led),
    .o_tx_disable(tx_dis), .o_negotiation_restart(restart),
    .o_far_end_fault_disable(fef_dis), .o_power_down(pwr_dn),
    .o_crossover_disable(xo_dis), .o_force_mdi(frc), .o_loopback(loop),
    .o_crossover_algorithm_select(alg));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Counts high cycles so a stretched pulse shows up
  always @(posedge clk_sys) begin
    for (int p = 0; p < 2; p++) if (restart[p] === 1'b1) pulse_cnt[p]++;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  // One idle edge first, so release and next setup never share a step
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                     input logic strb, input logic err, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, wd};
    pstrb   <= {3'b111, strb};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      bad_count++;
      wrap_up();
    end
    rd = prdata;
    `CHK("slave error", err, pslverr)
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd, 1'b1, 1'b0, rdv);
  endtask : wr
  task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00, 1'b1, 1'b0, rdv);
    `CHK($sformatf("register %h", idx), {24'h0, exp}, rdv)
  endtask : rd
  function automatic logic [5:0] ctl(input int p);
    return p == 0 ? `PPCS_IDX_P1_CTRL : `PPCS_IDX_P2_CTRL;
  endfunction : ctl
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {mdix, an, link, ability, pol, fef, txf, rxf, spd, dup} = '0;
    xo_strap = 1'b1;
    force_strap = 1'b0;
    led_src = 8'hA5;
    sys_rst = 1'b1;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(`PPCS_IDX_P1_CTRL, `PPCS_CTL_RST);
    rd(`PPCS_IDX_P2_CTRL, 8'h04);
    rd(`PPCS_IDX_P1_STAT, 8'h00);
    rd(`PPCS_IDX_P2_STAT, 8'h00);
    rd(`PPCS_IDX_P1_STATX, 8'h80);
    rd(`PPCS_IDX_P2_STATX, 8'h80);
    rd(`PPCS_IDX_P3_STATX, 8'h00);
    wr(`PPCS_IDX_P2_CTRL, 8'h00);
    // Each control bit alone on each port, outputs checked one cycle after update
    for (int p = 0; p < 2; p++) begin
      for (int b = 0; b < 8; b++) begin
        v = 8'h01 << b;
        wr(ctl(p), v);
        repeat (2) @(posedge clk_sys);
        exp_led = led_src;
        if (v[7]) exp_led[p*4+:4] = `PPCS_LED_BLANK;
        `CHK("led", exp_led, led)
        `CHK("tx disable", 2'(v[6]) << p, tx_dis)
        `CHK("fault disable", v[4] & (p == 0), fef_dis)
        `CHK("power down", 2'(v[3]) << p, pwr_dn)
        `CHK("crossover disable", 2'(v[2]) << p, xo_dis)
        `CHK("force mdi", 2'(v[1]) << p, frc)
        `CHK("loopback", 2'(v[0]) << p, loop)
        rd(ctl(p), b == 5 ? 8'h00 : v);
      end
      wr(ctl(p), 8'h00);
    end
    `CHK("restart pulses port 1", 1, pulse_cnt[0])
    `CHK("restart pulses port 2", 1, pulse_cnt[1])
    // Status snapshots for three input patterns
    for (int i = 0; i < 3; i++) begin
      pat = i == 0 ? 32'h5A5AC3C3 : i == 1 ? 32'hA5A53C3C : 32'h7FFFFFFF;
      {dup, spd, rxf, txf, fef, pol, ability, link, an, mdix} <= pat[30:0];
      repeat (2) @(posedge clk_sys);
      for (int p = 0; p < 2; p++) begin
        rd(p == 0 ? `PPCS_IDX_P1_STAT : `PPCS_IDX_P2_STAT,
           {mdix[p], an[p], link[p], ability[p*5+:5]});
        rd(p == 0 ? `PPCS_IDX_P1_STATX : `PPCS_IDX_P2_STATX, {2'b10, pol[p],
           txf[p], rxf[p], spd[p], dup[p], fef & (p == 0)});
      end
      rd(`PPCS_IDX_P3_STATX, {3'b000, txf[2], rxf[2], spd[2], dup[2], 1'b0});
    end
    {dup, spd, rxf, txf, fef, pol, ability, link, an, mdix} <= '0;
    // Writes to status, reserved and unmapped places, and a strobe-masked control write
    wr(`PPCS_IDX_P1_STATX, 8'h00);
    // Select output lags the stored bit by one cycle
    repeat (2) @(posedge clk_sys);
    `CHK("algorithm select", 2'b10, alg)
    rd(`PPCS_IDX_P1_STATX, 8'h00);
    // Reserved bit 6 is always written as zero
    wr(`PPCS_IDX_P2_STATX, 8'hBF);
    rd(`PPCS_IDX_P2_STATX, 8'h80);
    wr(`PPCS_IDX_P3_STATX, 8'hBF);
    rd(`PPCS_IDX_P3_STATX, 8'h00);
    wr(`PPCS_IDX_P1_STAT, 8'hFF);
    rd(`PPCS_IDX_P1_STAT, 8'h00);
    wr(`PPCS_IDX_P3_RSVC, 8'hFF);
    wr(`PPCS_IDX_P3_RSVS, 8'hFF);
    repeat (2) @(posedge clk_sys);
    `CHK("led after reserved write", led_src, led)
    rd(`PPCS_IDX_P3_RSVC, 8'h00);
    rd(`PPCS_IDX_P3_RSVS, 8'h00);
    apb(1'b1, 6'h1C, 8'hFF, 1'b1, 1'b1, rdv);
    apb(1'b0, 6'h1C, 8'h00, 1'b1, 1'b1, rdv);
    `CHK("unmapped read", 32'h0, rdv)
    apb(1'b1, `PPCS_IDX_P1_CTRL, 8'h40, 1'b0, 1'b0, rdv);
    rd(`PPCS_IDX_P1_CTRL, 8'h00);
    `CHK("tx disable after masked write", 2'b00, tx_dis)
    wrap_up();
  end
endmodule : port_phy_control_status_test
